//--- dcm_pkg.sv
/*
  Package for the debug comparator match registers: register indexes and
  byte addresses, reset values, selector codes and widths.
  Assumes a 32-bit APB slave where each register is one aligned word.
*/
`default_nettype none

package dcm_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_ADDR_MID      = 6'h2A;
  localparam logic [5:0] IDX_ADDR_LOW      = 6'h2B;
  localparam logic [5:0] IDX_DATA_HIGH     = 6'h2C;
  localparam logic [5:0] IDX_DATA_LOW      = 6'h2D;
  localparam logic [5:0] IDX_DATA_HIGH_MSK = 6'h2E;
  localparam logic [5:0] IDX_DATA_LOW_MSK  = 6'h2F;

  localparam logic [7:0] BA_ADDR_MID      = {IDX_ADDR_MID, 2'h0};
  localparam logic [7:0] BA_ADDR_LOW      = {IDX_ADDR_LOW, 2'h0};
  localparam logic [7:0] BA_DATA_HIGH     = {IDX_DATA_HIGH, 2'h0};
  localparam logic [7:0] BA_DATA_LOW      = {IDX_DATA_LOW, 2'h0};
  localparam logic [7:0] BA_DATA_HIGH_MSK = {IDX_DATA_HIGH_MSK, 2'h0};
  localparam logic [7:0] BA_DATA_LOW_MSK  = {IDX_DATA_LOW_MSK, 2'h0};

  // Widths
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;
  localparam int REG_W      = 8;
  localparam int NUM_CMP    = 3;

  // Reset values
  localparam logic [7:0]  RST_ADDR_BYTE = 8'h00;
  localparam logic [7:0]  RST_DATA_BYTE = 8'h00;
  localparam logic [7:0]  RST_MASK_BYTE = 8'h00;
  localparam logic [31:0] RST_RDATA     = 32'h0000_0000;

  // Comparator selector codes
  typedef enum logic [1:0] {
    VIEW_A    = 2'b00,
    VIEW_B    = 2'b01,
    VIEW_C    = 2'b10,
    VIEW_NONE = 2'b11
  } dcm_view_t;

endpackage : dcm_pkg

`default_nettype wire

//--- dcm_match_regs.sv
/*
  Debug comparator match registers: address mid/low bytes for comparators
  A, B and C behind a selector window, data and data mask bytes for
  comparator A, and the registered match outputs.
  Assumes the selector, armed and tag-select levels come from logic on the
  same clock, and that the monitored bus is synchronous to that clock.
*/
// Function
// R1: Mid byte of selected comparator holds expected address bits 15..8.
// R2: Low byte of selected comparator holds expected address bits 7..0.
// R3: Address compare bit one demands one on the bus, zero demands zero.
// R4: Address mid/low readable any time, showing the selected comparator.
// R5: Address compare writes land only while the debug module is unarmed.
// R6: Data and mask bytes read only when selector is 00.
// R7: Data and mask writes land only with selector 00 and module unarmed.
// R8: Data high byte gives expected data bits 15..8.
// R9: Data low byte gives expected data bits 7..0.
// R10: A data bit joins the match only when its mask bit is one.
// R11: Only comparator A stores data and mask; others never compare data.
// R12: Comparator A compares data only with tag select clear.
// R13: High mask byte selects which data bits 15..8 are checked.
// R14: Low mask byte selects which data bits 7..0 are checked.
// R15: Mask zero accepts any data value, mask one demands equality.
// R16: Selector 00/01/10 exposes A/B/C; 11 exposes no comparator.
// R17: With tag select set, match only when the tagged opcode executes.
// R18: A matches when address and masked data agree in one bus cycle.
`timescale 1ns/1ps
`default_nettype none

module dcm_match_regs (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [dcm_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic [dcm_pkg::APB_DATA_W-1:0] pwdata,
  output logic      [dcm_pkg::APB_DATA_W-1:0] prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Debug control state
  input  wire logic [1:0]                   comparatorViewSelect,
  input  wire logic                         debugArmed,
  input  wire logic [dcm_pkg::NUM_CMP-1:0]  tagSelect,
  // Monitored CPU bus
  input  wire logic                         busValid,
  input  wire logic [15:0]                  busAddr,
  input  wire logic [15:0]                  busData,
  input  wire logic                         opcodeExecute,
  // Match results
  output logic      [dcm_pkg::NUM_CMP-1:0]  match
);

  logic [7:0]  addrMid [dcm_pkg::NUM_CMP];
  logic [7:0]  addrLow [dcm_pkg::NUM_CMP];
  logic [7:0]  dataHigh;
  logic [7:0]  dataLow;
  logic [7:0]  dataHighMask;
  logic [7:0]  dataLowMask;
  logic [dcm_pkg::NUM_CMP-1:0] tagPending;
  logic [dcm_pkg::NUM_CMP-1:0] addrHit;
  logic [dcm_pkg::NUM_CMP-1:0] next_match;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        setup;
  logic        writeDone;
  logic        viewValid;
  logic        viewA;
  logic        addrWriteOk;
  logic        dataWriteOk;
  logic        dataOk;
  logic        mapped;

  assign setup       = psel && !penable;
  assign writeDone   = psel && penable && pready && pwrite;
  assign viewValid   = comparatorViewSelect != dcm_pkg::VIEW_NONE; // see R16
  assign viewA       = comparatorViewSelect == dcm_pkg::VIEW_A;
  assign addrWriteOk = writeDone && !debugArmed && viewValid; // see R5
  assign dataWriteOk = writeDone && !debugArmed && viewA; // see R7
  assign mapped      = paddr == dcm_pkg::BA_ADDR_MID || paddr == dcm_pkg::BA_ADDR_LOW
                    || paddr == dcm_pkg::BA_DATA_HIGH || paddr == dcm_pkg::BA_DATA_LOW
                    || paddr == dcm_pkg::BA_DATA_HIGH_MSK
                    || paddr == dcm_pkg::BA_DATA_LOW_MSK;

  // One wait-free access: ready rises in the access phase only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= dcm_pkg::RST_RDATA;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= setup ? next_prdata : dcm_pkg::RST_RDATA;
      pslverr <= setup && next_pslverr;
    end
  end

  // Read mux; gated registers read as zero rather than erroring
  always_comb begin
    next_prdata  = dcm_pkg::RST_RDATA;
    next_pslverr = !mapped;
    if (!pwrite) begin
      case (paddr)
        dcm_pkg::BA_ADDR_MID: begin
          if (viewValid) next_prdata = {24'h000000, addrMid[comparatorViewSelect]}; // see R4
        end
        dcm_pkg::BA_ADDR_LOW: begin
          if (viewValid) next_prdata = {24'h000000, addrLow[comparatorViewSelect]}; // see R4
        end
        dcm_pkg::BA_DATA_HIGH: begin
          if (viewA) next_prdata = {24'h000000, dataHigh}; // see R6
        end
        dcm_pkg::BA_DATA_LOW: begin
          if (viewA) next_prdata = {24'h000000, dataLow}; // see R6
        end
        dcm_pkg::BA_DATA_HIGH_MSK: begin
          if (viewA) next_prdata = {24'h000000, dataHighMask}; // see R6
        end
        dcm_pkg::BA_DATA_LOW_MSK: begin
          if (viewA) next_prdata = {24'h000000, dataLowMask}; // see R6
        end
        default: begin
          next_prdata = dcm_pkg::RST_RDATA;
        end
      endcase
    end
  end

  // Address compare bytes, one pair per comparator
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < dcm_pkg::NUM_CMP; i++) begin
        addrMid[i] <= dcm_pkg::RST_ADDR_BYTE;
        addrLow[i] <= dcm_pkg::RST_ADDR_BYTE;
      end
    end else if (addrWriteOk) begin
      if (paddr == dcm_pkg::BA_ADDR_MID) begin
        addrMid[comparatorViewSelect] <= pwdata[7:0]; // see R1
      end
      if (paddr == dcm_pkg::BA_ADDR_LOW) begin
        addrLow[comparatorViewSelect] <= pwdata[7:0]; // see R2
      end
    end
  end

  // Data and mask bytes exist for comparator A alone
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dataHigh     <= dcm_pkg::RST_DATA_BYTE;
      dataLow      <= dcm_pkg::RST_DATA_BYTE;
      dataHighMask <= dcm_pkg::RST_MASK_BYTE;
      dataLowMask  <= dcm_pkg::RST_MASK_BYTE;
    end else if (dataWriteOk) begin // see R11
      case (paddr)
        dcm_pkg::BA_DATA_HIGH:     dataHigh     <= pwdata[7:0]; // see R8
        dcm_pkg::BA_DATA_LOW:      dataLow      <= pwdata[7:0]; // see R9
        dcm_pkg::BA_DATA_HIGH_MSK: dataHighMask <= pwdata[7:0]; // see R13
        dcm_pkg::BA_DATA_LOW_MSK:  dataLowMask  <= pwdata[7:0]; // see R14
        default: begin
          dataHigh <= dataHigh;
        end
      endcase
    end
  end

  // Exact bitwise equality on the sixteen address bits
  always_comb begin
    for (int i = 0; i < dcm_pkg::NUM_CMP; i++) begin
      addrHit[i] = busValid && (busAddr == {addrMid[i], addrLow[i]}); // see R3
    end
  end

  // Mask zero lets a bit pass, mask one demands equality
  assign dataOk = ((busData ^ {dataHigh, dataLow}) & {dataHighMask, dataLowMask})
                  == 16'h0000; // see R10 see R15

  // Forced matches fire on the bus cycle; tagged ones wait for execution
  always_comb begin
    for (int i = 0; i < dcm_pkg::NUM_CMP; i++) begin
      next_match[i] = tagSelect[i] ? (tagPending[i] && opcodeExecute) // see R17
                                   : addrHit[i];
    end
    // Data only qualifies A, and only in the untagged case
    if (!tagSelect[0]) begin
      next_match[0] = addrHit[0] && dataOk; // see R12 see R18
    end
  end

  // Tag is held until the opcode executes; a new fetch in that cycle re-tags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tagPending <= '0;
    end else begin
      for (int i = 0; i < dcm_pkg::NUM_CMP; i++) begin
        if (!tagSelect[i]) begin
          tagPending[i] <= 1'b0;
        end else if (addrHit[i]) begin
          tagPending[i] <= 1'b1; // see R17
        end else if (opcodeExecute) begin
          tagPending[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      match <= '0;
    end else begin
      match <= next_match;
    end
  end

  sequence s_setupRead;
    psel && !penable && !pwrite;
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  property p_apbReady;
    @(posedge clock) disable iff (rst)
      (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_apbReady: assert property (p_apbReady) else $error("pready not one cycle after setup");

  property p_midWrite;
    @(posedge clock) disable iff (rst)
      (writeDone && !debugArmed && viewValid && paddr == dcm_pkg::BA_ADDR_MID)
      |=> addrMid[$past(comparatorViewSelect)] == $past(pwdata[7:0]);
  endproperty
  a_midWrite: assert property (p_midWrite) else $error("mid byte write lost"); // see R1

  property p_lowWrite;
    @(posedge clock) disable iff (rst)
      (writeDone && !debugArmed && viewValid && paddr == dcm_pkg::BA_ADDR_LOW)
      |=> addrLow[$past(comparatorViewSelect)] == $past(pwdata[7:0]);
  endproperty
  a_lowWrite: assert property (p_lowWrite) else $error("low byte write lost"); // see R2

  property p_armedHold;
    @(posedge clock) disable iff (rst)
      (writeDone && debugArmed) |=> $stable(addrMid[0]) && $stable(addrMid[1])
        && $stable(addrMid[2]) && $stable(addrLow[0]) && $stable(addrLow[1])
        && $stable(addrLow[2]) && $stable(dataHigh) && $stable(dataLow)
        && $stable(dataHighMask) && $stable(dataLowMask);
  endproperty
  a_armedHold: assert property (p_armedHold) else $error("write landed while armed"); // see R5

  property p_midRead;
    @(posedge clock) disable iff (rst)
      (s_setupRead ##0 (paddr == dcm_pkg::BA_ADDR_MID && viewValid)) |=>
      prdata[7:0] == addrMid[$past(comparatorViewSelect)] && prdata[31:8] == 24'h000000;
  endproperty
  a_midRead: assert property (p_midRead) else $error("mid read wrong comparator"); // see R4

  property p_dataReadGate;
    @(posedge clock) disable iff (rst)
      (s_setupRead ##0 (paddr == dcm_pkg::BA_DATA_HIGH && !viewA)) |=>
      s_access ##0 prdata == 32'h0;
  endproperty
  a_dataReadGate: assert property (p_dataReadGate) else $error("data read not gated"); // see R6

  property p_dataWriteGate;
    @(posedge clock) disable iff (rst)
      (writeDone && !viewA) |=> $stable(dataHigh) && $stable(dataLow)
        && $stable(dataHighMask) && $stable(dataLowMask);
  endproperty
  a_dataWriteGate: assert property (p_dataWriteGate) else $error("data write not gated"); // see R7

  property p_matchA;
    @(posedge clock) disable iff (rst)
      (!tagSelect[0] && busValid) |=> match[0] ==
        ($past(busAddr) == $past({addrMid[0], addrLow[0]}) &&
         (($past(busData) ^ $past({dataHigh, dataLow}))
          & $past({dataHighMask, dataLowMask})) == 16'h0);
  endproperty
  a_matchA: assert property (p_matchA) else $error("comparator A match wrong"); // see R18

  property p_tagNoExec;
    @(posedge clock) disable iff (rst)
      (tagSelect[0] && !opcodeExecute) |=> !match[0];
  endproperty
  a_tagNoExec: assert property (p_tagNoExec) else $error("tagged match before execute"); // see R17

  property p_matchB;
    @(posedge clock) disable iff (rst)
      (!tagSelect[1]) |=> match[1] ==
        ($past(busValid) && $past(busAddr) == $past({addrMid[1], addrLow[1]}));
  endproperty
  a_matchB: assert property (p_matchB) else $error("comparator B match wrong"); // see R3

  property p_matchC;
    @(posedge clock) disable iff (rst)
      (!tagSelect[2]) |=> match[2] ==
        ($past(busValid) && $past(busAddr) == $past({addrMid[2], addrLow[2]}));
  endproperty
  a_matchC: assert property (p_matchC) else $error("comparator C match wrong"); // see R3

  property p_lowRead;
    @(posedge clock) disable iff (rst)
      (s_setupRead ##0 (paddr == dcm_pkg::BA_ADDR_LOW && viewValid)) |=>
      prdata[7:0] == addrLow[$past(comparatorViewSelect)] && prdata[31:8] == 24'h000000;
  endproperty
  a_lowRead: assert property (p_lowRead) else $error("low read wrong comparator"); // see R4

  property p_noViewRead;
    @(posedge clock) disable iff (rst)
      (s_setupRead ##0 (paddr == dcm_pkg::BA_ADDR_MID && !viewValid)) |=>
      s_access ##0 prdata == 32'h0;
  endproperty
  a_noViewRead: assert property (p_noViewRead) else $error("hidden comparator read"); // see R16

  property p_dataRead;
    @(posedge clock) disable iff (rst)
      (s_setupRead ##0 (paddr == dcm_pkg::BA_DATA_LOW && viewA)) |=>
      s_access ##0 prdata == {24'h000000, dataLow};
  endproperty
  a_dataRead: assert property (p_dataRead) else $error("data low read wrong"); // see R6

  property p_dataWrite;
    @(posedge clock) disable iff (rst)
      (writeDone && !debugArmed && viewA && paddr == dcm_pkg::BA_DATA_HIGH)
      |=> dataHigh == $past(pwdata[7:0]);
  endproperty
  a_dataWrite: assert property (p_dataWrite) else $error("data high write lost"); // see R8

  property p_maskWrite;
    @(posedge clock) disable iff (rst)
      (writeDone && !debugArmed && viewA && paddr == dcm_pkg::BA_DATA_LOW_MSK)
      |=> dataLowMask == $past(pwdata[7:0]);
  endproperty
  a_maskWrite: assert property (p_maskWrite) else $error("low mask write lost"); // see R14

  // Tagged match ignores the data bytes entirely
  property p_tagExec;
    @(posedge clock) disable iff (rst)
      (tagSelect[0] && tagPending[0] && opcodeExecute) |=> match[0];
  endproperty
  a_tagExec: assert property (p_tagExec) else $error("tagged opcode did not match"); // see R12

endmodule : dcm_match_regs

`default_nettype wire

//--- dcm_bus_model.sv
/*
  Model of the monitored CPU bus: turns one bench request into one bus cycle.
  Assumes requests change just after a rising edge of the shared clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dcm_bus_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Requests from the bench
  input  wire logic        reqValid,
  input  wire logic        reqExec,
  input  wire logic [15:0] reqAddr,
  input  wire logic [15:0] reqData,
  // Bus towards the block
  output logic             busValid,
  output logic             opcodeExecute,
  output logic [15:0]      busAddr,
  output logic [15:0]      busData
);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busValid      <= 1'b0;
      opcodeExecute <= 1'b0;
      busAddr       <= 16'h0000;
      busData       <= 16'h0000;
    end else begin
      busValid      <= reqValid;
      opcodeExecute <= reqExec;
      // Idle bus shows the inverse, so a stale value never passes for a cycle
      busAddr       <= reqValid ? reqAddr : ~busAddr;
      busData       <= reqValid ? reqData : ~busData;
    end
  end
endmodule : dcm_bus_model

`default_nettype wire

//--- tb.sv
/*
  Self-checking bench for the debug comparator match registers.
  Assumes the zero-wait APB slave and one-cycle match latency of the block.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, debugArmed;
  logic        busValid, opcodeExecute, reqValid, reqExec;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  view;
  logic [2:0]  tagSelect, match;
  logic [15:0] busAddr, busData, reqAddr, reqData;
  int          n_fail = 0;
  int          tests_run = 0;
  int          cycles = 0;

  localparam logic [7:0] ADDRS [6] = '{dcm_pkg::BA_ADDR_MID, dcm_pkg::BA_ADDR_LOW,
    dcm_pkg::BA_DATA_HIGH, dcm_pkg::BA_DATA_LOW, dcm_pkg::BA_DATA_HIGH_MSK,
    dcm_pkg::BA_DATA_LOW_MSK};
  localparam logic [7:0] AM [4] = '{8'h12, 8'h56, 8'h9A, 8'hEE};
  localparam logic [7:0] AL [4] = '{8'h34, 8'h78, 8'hBC, 8'hEE};
  localparam logic [7:0] DV [4] = '{8'hA5, 8'h5A, 8'hF0, 8'h0F};

  dcm_match_regs dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparatorViewSelect(view), .debugArmed(debugArmed),
    .tagSelect(tagSelect), .busValid(busValid), .busAddr(busAddr), .busData(busData),
    .opcodeExecute(opcodeExecute), .match(match));

  dcm_bus_model bus_u (.clock(clock), .rst(rst), .reqValid(reqValid), .reqExec(reqExec),
    .reqAddr(reqAddr), .reqData(reqData), .busValid(busValid),
    .opcodeExecute(opcodeExecute), .busAddr(busAddr), .busData(busData));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // Generous ceiling: the whole run needs well under 1000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Request holds until pready is seen high at a rising edge; answer taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h000000, d}, r, e);
  endtask : wr

  task automatic rdChk(input string nm, input logic [7:0] a, input logic [7:0] x,
                       input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(nm, r, {24'h000000, x});
    chk({nm, " slave error"}, {31'h0, e}, {31'h0, xe});
  endtask : rdChk

  task automatic busCyc(input logic [15:0] a, input logic [15:0] d, input logic v,
                        input logic x, input logic [2:0] exp, input string nm);
    @(posedge clock);
    reqValid <= v;
    reqExec  <= x;
    reqAddr  <= a;
    reqData  <= d;
    @(posedge clock);
    reqValid <= 1'b0;
    reqExec  <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk(nm, {29'h0, match}, {29'h0, exp});
  endtask : busCyc

  task automatic t_reset;
    foreach (ADDRS[i]) rdChk("reset value", ADDRS[i], 8'h00, 1'b0);
    rdChk("unmapped", 8'h00, 8'h00, 1'b1);
    $display("reset test done");
  endtask : t_reset

  task automatic t_addr;
    for (int v = 0; v < 4; v++) begin
      @(posedge clock) view <= 2'(v);
      wr(dcm_pkg::BA_ADDR_MID, AM[v]);
      wr(dcm_pkg::BA_ADDR_LOW, AL[v]);
    end
    for (int v = 0; v < 4; v++) begin
      @(posedge clock) view <= 2'(v);
      rdChk("addr mid", dcm_pkg::BA_ADDR_MID, v == 3 ? 8'h00 : AM[v], 1'b0);
      rdChk("addr low", dcm_pkg::BA_ADDR_LOW, v == 3 ? 8'h00 : AL[v], 1'b0);
    end
    $display("address register test done");
  endtask : t_addr

  task automatic t_data;
    @(posedge clock) view <= 2'b00;
    foreach (DV[i]) wr(ADDRS[i+2], DV[i]);
    @(posedge clock) view <= 2'b01;
    wr(dcm_pkg::BA_DATA_HIGH, 8'h77);
    rdChk("data hidden", dcm_pkg::BA_DATA_HIGH, 8'h00, 1'b0);
    @(posedge clock) view <= 2'b00;
    foreach (DV[i]) rdChk("data regs", ADDRS[i+2], DV[i], 1'b0);
    @(posedge clock) debugArmed <= 1'b1;
    wr(dcm_pkg::BA_ADDR_MID, 8'h99);
    wr(dcm_pkg::BA_DATA_LOW, 8'h99);
    @(posedge clock) debugArmed <= 1'b0;
    rdChk("armed addr", dcm_pkg::BA_ADDR_MID, 8'h12, 1'b0);
    rdChk("armed data", dcm_pkg::BA_DATA_LOW, 8'h5A, 1'b0);
    $display("data register test done");
  endtask : t_data

  task automatic t_match;
    busCyc(16'h1234, 16'hA55A, 1'b1, 1'b0, 3'b001, "exact hit");
    busCyc(16'h1234, 16'hAFFA, 1'b1, 1'b0, 3'b001, "masked bits");
    busCyc(16'h1234, 16'hB55A, 1'b1, 1'b0, 3'b000, "high data");
    busCyc(16'h1234, 16'hA55B, 1'b1, 1'b0, 3'b000, "low data");
    busCyc(16'h1235, 16'hA55A, 1'b1, 1'b0, 3'b000, "addr low bit");
    busCyc(16'h1334, 16'hA55A, 1'b1, 1'b0, 3'b000, "addr mid bit");
    busCyc(16'h5678, 16'h0000, 1'b1, 1'b0, 3'b010, "comparator b");
    busCyc(16'h9ABC, 16'hFFFF, 1'b1, 1'b0, 3'b100, "comparator c");
    @(posedge clock) tagSelect <= 3'b001;
    busCyc(16'h1234, 16'h0000, 1'b1, 1'b0, 3'b000, "tag hit");
    busCyc(16'h0000, 16'h0000, 1'b0, 1'b1, 3'b001, "tag exec");
    @(posedge clock) tagSelect <= 3'b000;
    $display("match test done");
  endtask : t_match

  initial begin
    rst        = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h00000000;
    view       = 2'b00;
    debugArmed = 1'b0;
    tagSelect  = 3'b000;
    reqValid   = 1'b0;
    reqExec    = 1'b0;
    reqAddr    = 16'h0000;
    reqData    = 16'h0000;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_addr();
    t_data();
    t_match();
    results();
  end
endmodule : tb

`default_nettype wire
